// file: dv/dtc_chk_properties.sv
// Purpose: Port-level checks of the dual timer block
// Assumes: One clock, synchronous active-low reset
// Notes: Flag checks expect no rollover on the edge of their cause
`timescale 1ns/1ps
`default_nettype none
module dtc_chk (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // Register port
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic [7:0] SFR_RDATA,
    // Acknowledges and pins
    input wire logic TIMER0_VECTOR_ACK,
    input wire logic TIMER1_VECTOR_ACK,
    input wire logic EXTERNAL_INTERRUPT_PIN_ZERO_B,
    // Status
    input wire logic TIMER0_OVERFLOW_FLAG,
    input wire logic TIMER1_OVERFLOW_FLAG,
    input wire logic EXT_EXTERNAL_INTERRUPT_PIN_ZERO_DETECT_FLAG,
    input wire logic CPU_CLOCK_STOP
);
    // ==========================================================
    // Checks
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);
    sequence s_ck_wr;
        SFR_WR && SFR_ADDR == 8'h8E;
    endsequence
    sequence s_ck_rd;
        SFR_RD && SFR_ADDR == 8'h8E;
    endsequence
    tf0_ack_clear_a: assert property (
        TIMER0_VECTOR_ACK && !SFR_WR |=> !TIMER0_OVERFLOW_FLAG)
        else $error("timer 0 flag kept after ack");
    tf1_ack_clear_a: assert property (
        TIMER1_VECTOR_ACK && !SFR_WR |=> !TIMER1_OVERFLOW_FLAG)
        else $error("timer 1 flag kept after ack");
    flag_write_a: assert property (
        SFR_WR && SFR_ADDR == 8'h88 |=>
        TIMER1_OVERFLOW_FLAG == $past(SFR_WDATA[7]) &&
        TIMER0_OVERFLOW_FLAG == $past(SFR_WDATA[5]))
        else $error("overflow flags ignore a write");
    flag_read_a: assert property (
        SFR_RD && SFR_ADDR == 8'h88 |=>
        SFR_RDATA[7] == $past(TIMER1_OVERFLOW_FLAG) &&
        SFR_RDATA[1] == $past(EXT_EXTERNAL_INTERRUPT_PIN_ZERO_DETECT_FLAG))
        else $error("control read differs from flags");
    clk_sel_read_a: assert property (
        s_ck_wr ##2 s_ck_rd |=> SFR_RDATA == $past(SFR_WDATA, 3))
        else $error("clock select readback wrong");
    external_interrupt_pin_zero_detect_a: assert property (
        $fell(EXTERNAL_INTERRUPT_PIN_ZERO_B) |-> ##[1:2] EXT_EXTERNAL_INTERRUPT_PIN_ZERO_DETECT_FLAG)
        else $error("pin 0 fall not detected");
    idle_stop_a: assert property (
        SFR_WR && SFR_ADDR == 8'h87 && SFR_WDATA[0] |->
        ##[1:2] CPU_CLOCK_STOP)
        else $error("idle request did not stop core clock");
    pd_freeze_a: assert property (
        SFR_WR && SFR_ADDR == 8'h87 && SFR_WDATA[1] |=> ##2
        ($stable(TIMER0_OVERFLOW_FLAG) && CPU_CLOCK_STOP) [*8])
        else $error("state moved in power down");
endmodule
bind dtc_timer_block dtc_chk i_chk (.CLK(CLK), .RST_B(RST_B),
    .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_ADDR(SFR_ADDR),
    .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
    .TIMER0_VECTOR_ACK(TIMER0_VECTOR_ACK),
    .TIMER1_VECTOR_ACK(TIMER1_VECTOR_ACK),
    .EXTERNAL_INTERRUPT_PIN_ZERO_B(EXTERNAL_INTERRUPT_PIN_ZERO_B),
    .TIMER0_OVERFLOW_FLAG(TIMER0_OVERFLOW_FLAG),
    .TIMER1_OVERFLOW_FLAG(TIMER1_OVERFLOW_FLAG),
    .EXT_EXTERNAL_INTERRUPT_PIN_ZERO_DETECT_FLAG(EXT_EXTERNAL_INTERRUPT_PIN_ZERO_DETECT_FLAG),
    .CPU_CLOCK_STOP(CPU_CLOCK_STOP));
`default_nettype wire

// file: dv/dtc_core_model.sv
// Purpose: Processor core model on the register port
// Assumes: Requests launch 1 ns after a rising edge
// Notes: Released address shows the inverse of the last value; write data is inverted only after a write
`timescale 1ns/1ps
`default_nettype none
module dtc_core_model (
    // Clock
    input wire logic CLK,
    // Register port
    output logic SFR_WR,
    output logic SFR_RD,
    output logic [7:0] SFR_ADDR,
    output logic [7:0] SFR_WDATA,
    input wire logic [7:0] SFR_RDATA,
    // Vector acknowledges
    output logic [3:0] ACK
);
    // ==========================================================
    // Bus tasks
    initial begin
        {SFR_WR, SFR_RD, ACK} = 6'h00;
        {SFR_ADDR, SFR_WDATA} = 16'h0000;
    end
    task automatic wr(input logic [7:0] a, d);
        @(posedge CLK);
        #1;
        {SFR_WR, SFR_ADDR, SFR_WDATA} = {1'b1, a, d};
        @(posedge CLK);
        #1;
        {SFR_WR, SFR_ADDR, SFR_WDATA} = {1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge CLK);
        #1;
        {SFR_RD, SFR_ADDR} = {1'b1, a};
        @(posedge CLK);
        #1;
        {SFR_RD, SFR_ADDR} = {1'b0, ~a};
        d = SFR_RDATA;
    endtask
    task automatic ack(input int i);
        @(posedge CLK);
        #1;
        ACK[i] = 1'b1;
        @(posedge CLK);
        #1;
        ACK[i] = 1'b0;
    endtask
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// Purpose: Self-checking bench for the dual timer block
// Assumes: Core model drives the register port and acknowledges
// Notes: Cycle windows allow for the unknown divider phase
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ==========================================================
    // Signals and instances
    logic clk, rst_b, wr, rd, p0_b, p1_b, c0, c1, tf0, tf1, ie0, ie1, cs;
    logic [7:0] adr, wd, rdt, v;
    logic [3:0] ack;
    int n_fail, tests_run, n;
    dtc_core_model i_core (.CLK(clk), .SFR_WR(wr), .SFR_RD(rd),
        .SFR_ADDR(adr), .SFR_WDATA(wd), .SFR_RDATA(rdt), .ACK(ack));
    dtc_timer_block i_dut (.CLK(clk), .RST_B(rst_b), .SFR_WR(wr),
        .SFR_RD(rd), .SFR_ADDR(adr), .SFR_WDATA(wd), .SFR_RDATA(rdt),
        .TIMER0_VECTOR_ACK(ack[0]), .TIMER1_VECTOR_ACK(ack[1]),
        .EXT_EXTERNAL_INTERRUPT_PIN_ZERO_VECTOR_ACK(ack[2]), .EXT_EXTERNAL_INTERRUPT_PIN_ONE_VECTOR_ACK(ack[3]),
        .EXTERNAL_INTERRUPT_PIN_ZERO_B(p0_b),
        .EXTERNAL_INTERRUPT_PIN_ONE_B(p1_b), .COUNT_PIN0(c0),
        .COUNT_PIN1(c1), .TIMER0_OVERFLOW_FLAG(tf0),
        .TIMER1_OVERFLOW_FLAG(tf1), .EXT_EXTERNAL_INTERRUPT_PIN_ZERO_DETECT_FLAG(ie0),
        .EXT_EXTERNAL_INTERRUPT_PIN_ONE_DETECT_FLAG(ie1), .CPU_CLOCK_STOP(cs));
    // ==========================================================
    // Tasks
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [7:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic chk_rng(input string s, input int lo, hi, g);
        tests_run++;
        if (g < lo || g > hi) begin
            n_fail++;
            $display("MISMATCH %s exp %0d..%0d got %0d", s, lo, hi, g);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic rdc(input logic [7:0] a, e);
        i_core.rd(a, v);
        chk("register", e, v);
    endtask
    // Bounded wait; a miss ends the run
    task automatic wait_f(input int w);
        n = 0;
        while ((w ? tf1 : tf0) !== 1'b1) begin
            cyc(1);
            n++;
            if (n > 400) begin
                n_fail++;
                $display("MISMATCH overflow exp 1 got 0");
                complete_run();
            end
        end
    endtask
    task automatic go(input logic [7:0] m, k, al, l, ah, h, t);
        i_core.wr(8'h88, 8'h00);
        i_core.wr(8'h89, m);
        i_core.wr(8'h8E, k);
        i_core.wr(al, l);
        i_core.wr(ah, h);
        i_core.wr(8'h88, t);
    endtask
    task automatic ovf(input int w, lo, hi,
        input logic [7:0] m, k, al, l, ah, h, t);
        go(m, k, al, l, ah, h, t);
        wait_f(w);
        chk_rng("cycles to overflow", lo, hi, n);
    endtask
    task automatic ack_chk(input int w);
        i_core.ack(w);
        chk("overflow flag", 8'h00, {7'h00, w ? tf1 : tf0});
    endtask
    // ==========================================================
    // Sequence
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        {n_fail, tests_run} = 0;
        rst_b = 1'b0;
        {p0_b, p1_b, c0, c1} = 4'hF;
        cyc(6);
        rst_b = 1'b1;
        for (int a = 8'h88; a <= 8'h8E; a++) begin
            rdc(a[7:0], (a == 8'h8E) ? 8'h01 : 8'h00);
        end
        rdc(8'h90, 8'hFF);
        i_core.wr(8'h88, 8'hA0);
        chk("flags set", 8'h03, {6'h00, tf1, tf0});
        i_core.wr(8'h8E, 8'h19);
        rdc(8'h8E, 8'h19);
        ovf(0, 5, 18, 8'h01, 8'h09, 8'h8A, 8'hFD, 8'h8C, 8'hFF, 8'h10);
        ack_chk(0);
        ovf(0, 20, 44, 8'h01, 8'h01, 8'h8A, 8'hFD, 8'h8C, 8'hFF, 8'h10);
        ovf(0, 5, 18, 8'h00, 8'h09, 8'h8A, 8'hFD, 8'h8C, 8'hFF, 8'h10);
        i_core.rd(8'h8A, v);
        chk("prescaler top", 8'hE0, v & 8'hE0);
        ovf(0, 5, 18, 8'h02, 8'h09, 8'h8A, 8'hFD, 8'h8C, 8'hA5, 8'h10);
        rdc(8'h8C, 8'hA5);
        i_core.rd(8'h8A, v);
        chk_rng("reload", 8'hA5, 8'hA8, v);
        ovf(1, 5, 18, 8'h10, 8'h11, 8'h8B, 8'hFD, 8'h8D, 8'hFF, 8'h40);
        ack_chk(1);
        ovf(1, 5, 18, 8'h03, 8'h11, 8'h8A, 8'h00, 8'h8C, 8'hFD, 8'h40);
        rdc(8'h8A, 8'h00);
        go(8'h30, 8'h11, 8'h8B, 8'hFD, 8'h8D, 8'hFF, 8'h40);
        cyc(60);
        rdc(8'h8B, 8'hFD);
        p0_b = 1'b0;
        go(8'h09, 8'h09, 8'h8A, 8'hFD, 8'h8C, 8'hFF, 8'h10);
        cyc(40);
        rdc(8'h8A, 8'hFD);
        p0_b = 1'b1;
        wait_f(0);
        go(8'h05, 8'h09, 8'h8A, 8'hFE, 8'h8C, 8'hFF, 8'h10);
        cyc(30);
        rdc(8'h8A, 8'hFE);
        repeat (2) begin
            c0 = 1'b0;
            cyc(2);
            c0 = 1'b1;
            cyc(2);
        end
        chk("counter flag", 8'h01, {7'h00, tf0});
        i_core.wr(8'h88, 8'h05);
        {p0_b, p1_b} = 2'b00;
        cyc(3);
        {p0_b, p1_b} = 2'b11;
        cyc(3);
        chk("edge flags", 8'h03, {6'h00, ie1, ie0});
        i_core.ack(2);
        i_core.ack(3);
        chk("edge flags", 8'h00, {6'h00, ie1, ie0});
        i_core.wr(8'h88, 8'h00);
        p1_b = 1'b0;
        cyc(3);
        i_core.ack(3);
        chk("level flag", 8'h01, {7'h00, ie1});
        p1_b = 1'b1;
        cyc(3);
        chk("level flag", 8'h00, {7'h00, ie1});
        go(8'h01, 8'h01, 8'h8A, 8'hFD, 8'h8C, 8'hFF, 8'h10);
        i_core.wr(8'h87, 8'h01);
        cyc(2);
        chk("clock stop", 8'h01, {7'h00, cs});
        wait_f(0);
        go(8'h01, 8'h01, 8'h8A, 8'hFD, 8'h8C, 8'hFF, 8'h10);
        i_core.wr(8'h87, 8'h02);
        cyc(60);
        chk("frozen flag", 8'h00, {7'h00, tf0});
        rst_b = 1'b0;
        cyc(2);
        rst_b = 1'b1;
        chk("clock stop", 8'h00, {7'h00, cs});
        rdc(8'h87, 8'h00);
        rdc(8'h8E, 8'h01);
        complete_run();
    end
endmodule
`default_nettype wire

// file: rtl/dtc_pkg.sv
// Purpose: Constants for the dual timer/counter and external interrupt flags
// Assumes: Byte-wide special function register port, one system clock
// Notes: Mode register address is not fixed by the map; value chosen here
package dtc_pkg;
    // ==========================================================
    // Register addresses
    localparam logic [7:0] ADDR_TIMER_CTRL_FLAGS = 8'h88;
    localparam logic [7:0] ADDR_TIMER_MODE_CONFIG = 8'h89;
    localparam logic [7:0] ADDR_TIMER0_COUNT_LOW = 8'h8A;
    localparam logic [7:0] ADDR_TIMER1_COUNT_LOW = 8'h8B;
    localparam logic [7:0] ADDR_TIMER0_COUNT_HIGH = 8'h8C;
    localparam logic [7:0] ADDR_TIMER1_COUNT_HIGH = 8'h8D;
    localparam logic [7:0] ADDR_CLOCK_RATE_SELECT = 8'h8E;
    localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
    // ==========================================================
    // Control/flag register bit positions
    localparam int T1_OVF_POS = 7;
    localparam int T1_RUN_POS = 6;
    localparam int T0_OVF_POS = 5;
    localparam int T0_RUN_POS = 4;
    localparam int X1_FLAG_POS = 3;
    localparam int X1_TYPE_POS = 2;
    localparam int X0_FLAG_POS = 1;
    localparam int X0_TYPE_POS = 0;
    // Mode register: timer 1 in upper nibble, timer 0 in lower
    localparam int GATE_POS = 3;
    localparam int CT_POS = 2;
    localparam int MSEL_HI_POS = 1;
    localparam int MSEL_LO_POS = 0;
    localparam int T1_NIBBLE = 4;
    // Clock rate select bits
    localparam int T1_FAST_POS = 4;
    localparam int T0_FAST_POS = 3;
    // Power control bits
    localparam int STOP_ALL_POS = 1;
    localparam int HALT_CPU_POS = 0;
    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_RATE_SEL = 8'h01;
    // ==========================================================
    // Time base dividers
    localparam logic [3:0] DIV_FAST = 4'h4;
    localparam logic [3:0] DIV_SLOW = 4'hC;
    localparam logic [4:0] PRESCALE_MAX = 5'h1F;
    typedef enum logic [1:0] {
        DTC_MODE0 = 2'b00,
        DTC_MODE1 = 2'b01,
        DTC_MODE2 = 2'b10,
        DTC_MODE3 = 2'b11
    } dtc_mode_e;
endpackage

// file: rtl/dtc_tick_div.sv
// Purpose: Time base divider giving a one-cycle tick every 4 or 12 clocks
// Assumes: Runs only while its clock enable is high
// Notes: Rate change takes effect in the current period; a count already past the new limit wraps at once
`timescale 1ns/1ps
`default_nettype none
module dtc_tick_div (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // Control
    input wire logic ENABLE,
    input wire logic FAST,
    // Tick
    output logic TICK
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [3:0] limit;
    logic wrap;

    assign limit = FAST ? dtc_pkg::DIV_FAST : dtc_pkg::DIV_SLOW; // R13
    assign wrap = (cnt_q >= limit - 4'h1);
    assign cnt_d = wrap ? 4'h0 : cnt_q + 4'h1;

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            cnt_q <= 4'h0;
            TICK <= 1'b0;
        end else if (ENABLE) begin
            cnt_q <= cnt_d;
            TICK <= wrap;
        end else begin
            TICK <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: rtl/dtc_timer_block.sv
// Purpose: Timer/counters 0 and 1 with external interrupt detect flags
// Assumes: SFR port writes and reads are single-cycle; pins synchronous
// Notes: Read data is registered, one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
// Contract
// R01 - Timer 1 overflow sets flag, vector clears
// R02 - Timer 0 overflow sets flag, vector clears
// R03 - Run bit starts and stops each timer
// R04 - Detect flag: edge cleared on vector, level follows
// R05 - Type bit: falling edge or low level
// R06 - Gate bit needs pin high plus run
// R07 - Counter select: divided clock or falling pin
// R08 - Mode 0: 8-bit counter, 5-bit prescaler
// R09 - Mode 1: full 16-bit counter
// R10 - Mode 2: low byte reloads from high
// R11 - Mode 3: timer 0 split into two
// R12 - Timer 1 mode 3 holds count frozen
// R13 - Clock select: divide by 4 or 12
// R14 - Idle keeps timers and flags clocked
// R15 - Power down freezes all timer state
// R16 - Mode 0 prescaler is low five bits
// R17 - Mode 3 high byte uses timer 1 controls
module dtc_timer_block (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // Special function register port
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] SFR_RDATA,
    // Interrupt acknowledge from the core
    input wire logic TIMER0_VECTOR_ACK,
    input wire logic TIMER1_VECTOR_ACK,
    input wire logic EXT_EXTERNAL_INTERRUPT_PIN_ZERO_VECTOR_ACK,
    input wire logic EXT_EXTERNAL_INTERRUPT_PIN_ONE_VECTOR_ACK,
    // Pins (active-low interrupt pins)
    input wire logic EXTERNAL_INTERRUPT_PIN_ZERO_B,
    input wire logic EXTERNAL_INTERRUPT_PIN_ONE_B,
    input wire logic COUNT_PIN0,
    input wire logic COUNT_PIN1,
    // Status outputs
    output logic TIMER0_OVERFLOW_FLAG,
    output logic TIMER1_OVERFLOW_FLAG,
    output logic EXT_EXTERNAL_INTERRUPT_PIN_ZERO_DETECT_FLAG,
    output logic EXT_EXTERNAL_INTERRUPT_PIN_ONE_DETECT_FLAG,
    output logic CPU_CLOCK_STOP
);
    // ==========================================================
    // Registers
    logic [7:0] flags_q;
    logic [7:0] mode_cfg_q;
    logic [7:0] rate_sel_q;
    logic [7:0] pwr_ctl_q;
    // Count halves kept apart so mode 3 can split them
    logic [7:0] t0_lo_q;
    logic [7:0] t0_hi_q;
    logic [7:0] t1_lo_q;
    logic [7:0] t1_hi_q;
    logic [7:0] t0_lo_d;
    logic [7:0] t0_hi_d;
    logic [7:0] t1_lo_d;
    logic [7:0] t1_hi_d;
    logic [1:0] t_pin_q;
    logic [1:0] int_pin_q;
    logic [7:0] rdata_d;
    logic run_clk;
    logic tick0;
    logic tick1;

    function automatic logic wr_hit(input logic [7:0] a,
                                    input logic [7:0] target);
        wr_hit = SFR_WR && (a == target);
    endfunction

    // Power down stops everything; idle only stops the core
    assign run_clk = !pwr_ctl_q[dtc_pkg::STOP_ALL_POS]; // R15

    // Dividers run regardless of run bits, so the first tick after
    // starting a timer lands anywhere within one divider period
    dtc_tick_div u_div0 (
        .CLK(CLK),
        .RST_B(RST_B),
        .ENABLE(run_clk),
        .FAST(rate_sel_q[dtc_pkg::T0_FAST_POS]),
        .TICK(tick0)
    );
    dtc_tick_div u_div1 (
        .CLK(CLK),
        .RST_B(RST_B),
        .ENABLE(run_clk),
        .FAST(rate_sel_q[dtc_pkg::T1_FAST_POS]),
        .TICK(tick1)
    );

    // ==========================================================
    // Count enables
    logic [3:0] t0_cfg, t1_cfg;
    dtc_pkg::dtc_mode_e mode0, mode1;
    logic [1:0] int_lvl, t_fall, int_fall;
    logic gate_ok0, gate_ok1, inc0, inc1, inc_hi0_split;

    assign t0_cfg = mode_cfg_q[3:0];
    assign t1_cfg = mode_cfg_q[7:4];
    assign mode0 = dtc_pkg::dtc_mode_e'(t0_cfg[1:0]);
    assign mode1 = dtc_pkg::dtc_mode_e'(t1_cfg[1:0]);
    assign int_lvl = {EXTERNAL_INTERRUPT_PIN_ONE_B,
                      EXTERNAL_INTERRUPT_PIN_ZERO_B};
    assign t_fall = t_pin_q & ~{COUNT_PIN1, COUNT_PIN0};
    assign int_fall = int_pin_q & ~int_lvl;

    assign gate_ok0 = flags_q[dtc_pkg::T0_RUN_POS] &&
        (!t0_cfg[dtc_pkg::GATE_POS] || int_lvl[0]); // R03 R06
    assign gate_ok1 = flags_q[dtc_pkg::T1_RUN_POS] &&
        (!t1_cfg[dtc_pkg::GATE_POS] || int_lvl[1]); // R03 R06
    assign inc0 = run_clk && gate_ok0 &&
        (t0_cfg[dtc_pkg::CT_POS] ? t_fall[0] : tick0); // R07 R14
    assign inc1 = run_clk && gate_ok1 && (mode1 != dtc_pkg::DTC_MODE3) &&
        (t1_cfg[dtc_pkg::CT_POS] ? t_fall[1] : tick1); // R07 R12
    // Split high byte is timer only: internal tick, timer 1 run bit
    assign inc_hi0_split = run_clk && (mode0 == dtc_pkg::DTC_MODE3) &&
        flags_q[dtc_pkg::T1_RUN_POS] && tick1; // R11 R17

    // ==========================================================
    // Counter next-state per mode
    logic ovf0;
    logic ovf1;
    logic ovf_hi0;

    function automatic logic [16:0] step(input dtc_pkg::dtc_mode_e m,
                                          input logic [7:0] lo,
                                          input logic [7:0] hi);
        logic [16:0] r;
        r = {1'b0, hi, lo};
        case (m)
            dtc_pkg::DTC_MODE0: begin
                if (lo[4:0] == dtc_pkg::PRESCALE_MAX) begin
                    r = {hi == 8'hFF, hi + 8'h01, lo[7:5], 5'h00}; // R16
                end else begin
                    r = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01}; // R08
                end
            end
            dtc_pkg::DTC_MODE1: begin
                r = {1'b0, hi, lo} + 17'h00001; // R09
            end
            dtc_pkg::DTC_MODE2: begin
                if (lo == 8'hFF) begin
                    r = {1'b1, hi, hi}; // R10
                end else begin
                    r = {1'b0, hi, lo + 8'h01};
                end
            end
            dtc_pkg::DTC_MODE3: begin
                r = {lo == 8'hFF, hi, lo + 8'h01}; // R11
            end
            default: r = {1'b0, hi, lo};
        endcase
        step = r;
    endfunction

    logic [16:0] nxt0, nxt1;
    assign nxt0 = step(mode0, t0_lo_q, t0_hi_q);
    assign nxt1 = step(mode1, t1_lo_q, t1_hi_q);
    assign ovf0 = inc0 && nxt0[16];
    assign ovf1 = inc1 && nxt1[16];
    assign ovf_hi0 = inc_hi0_split && (t0_hi_q == 8'hFF);

    // A software write to a count byte wins over a same-cycle increment
    always_comb begin
        t0_lo_d = t0_lo_q;
        t0_hi_d = t0_hi_q;
        t1_lo_d = t1_lo_q;
        t1_hi_d = t1_hi_q;
        if (inc0) begin
            t0_lo_d = nxt0[7:0];
            if (mode0 != dtc_pkg::DTC_MODE3) begin
                t0_hi_d = nxt0[15:8];
            end
        end
        if (inc_hi0_split) begin
            t0_hi_d = t0_hi_q + 8'h01; // R11
        end
        if (inc1) begin
            t1_lo_d = nxt1[7:0];
            t1_hi_d = nxt1[15:8];
        end
        if (wr_hit(SFR_ADDR, dtc_pkg::ADDR_TIMER0_COUNT_LOW)) t0_lo_d = SFR_WDATA;
        if (wr_hit(SFR_ADDR, dtc_pkg::ADDR_TIMER0_COUNT_HIGH)) t0_hi_d = SFR_WDATA;
        if (wr_hit(SFR_ADDR, dtc_pkg::ADDR_TIMER1_COUNT_LOW)) t1_lo_d = SFR_WDATA;
        if (wr_hit(SFR_ADDR, dtc_pkg::ADDR_TIMER1_COUNT_HIGH)) t1_hi_d = SFR_WDATA;
    end

    // ==========================================================
    // Control and flag register
    logic [7:0] flags_d;
    logic [7:0] flags_out;
    logic set_tf1;
    assign set_tf1 = ovf1 || ovf_hi0; // R17
    // Status pins follow the stored bits, so they freeze in power down
    assign flags_out = run_clk ? flags_d : flags_q; // R15

    always_comb begin
        flags_d = flags_q;
        if (wr_hit(SFR_ADDR, dtc_pkg::ADDR_TIMER_CTRL_FLAGS)) begin
            flags_d = SFR_WDATA;
        end
        // Vector clears override software writes; events override both,
        // so an overflow in the acknowledge cycle is never lost
        if (TIMER1_VECTOR_ACK) flags_d[dtc_pkg::T1_OVF_POS] = 1'b0; // R01
        if (TIMER0_VECTOR_ACK) flags_d[dtc_pkg::T0_OVF_POS] = 1'b0; // R02
        if (set_tf1) flags_d[dtc_pkg::T1_OVF_POS] = 1'b1; // R01
        if (ovf0) flags_d[dtc_pkg::T0_OVF_POS] = 1'b1; // R02
        // Level mode rewrites the detect bit each cycle from the pin
        if (flags_q[dtc_pkg::X0_TYPE_POS]) begin
            if (EXT_EXTERNAL_INTERRUPT_PIN_ZERO_VECTOR_ACK) flags_d[dtc_pkg::X0_FLAG_POS] = 1'b0; // R04
            if (int_fall[0]) flags_d[dtc_pkg::X0_FLAG_POS] = 1'b1; // R05
        end else begin
            flags_d[dtc_pkg::X0_FLAG_POS] = !int_lvl[0]; // R04 R05
        end
        if (flags_q[dtc_pkg::X1_TYPE_POS]) begin
            if (EXT_EXTERNAL_INTERRUPT_PIN_ONE_VECTOR_ACK) flags_d[dtc_pkg::X1_FLAG_POS] = 1'b0; // R04
            if (int_fall[1]) flags_d[dtc_pkg::X1_FLAG_POS] = 1'b1; // R05
        end else begin
            flags_d[dtc_pkg::X1_FLAG_POS] = !int_lvl[1]; // R04 R05
        end
    end

    // ==========================================================
    // Read mux; unmapped addresses read high like unimplemented SFRs
    always_comb begin
        case (SFR_ADDR)
            dtc_pkg::ADDR_TIMER_CTRL_FLAGS: rdata_d = flags_q;
            dtc_pkg::ADDR_TIMER_MODE_CONFIG: rdata_d = mode_cfg_q;
            dtc_pkg::ADDR_TIMER0_COUNT_LOW: rdata_d = t0_lo_q;
            dtc_pkg::ADDR_TIMER1_COUNT_LOW: rdata_d = t1_lo_q;
            dtc_pkg::ADDR_TIMER0_COUNT_HIGH: rdata_d = t0_hi_q;
            dtc_pkg::ADDR_TIMER1_COUNT_HIGH: rdata_d = t1_hi_q;
            dtc_pkg::ADDR_CLOCK_RATE_SELECT: rdata_d = rate_sel_q;
            dtc_pkg::ADDR_POWER_CONTROL: rdata_d = pwr_ctl_q;
            default: rdata_d = 8'hFF;
        endcase
    end

    // ==========================================================
    // State update; power down freezes counters and flags
    // Limitation: once power down is set only reset brings it back
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            flags_q <= dtc_pkg::RST_BYTE;
            mode_cfg_q <= dtc_pkg::RST_BYTE;
            rate_sel_q <= dtc_pkg::RST_RATE_SEL;
            pwr_ctl_q <= dtc_pkg::RST_BYTE;
            t0_lo_q <= dtc_pkg::RST_BYTE;
            t0_hi_q <= dtc_pkg::RST_BYTE;
            t1_lo_q <= dtc_pkg::RST_BYTE;
            t1_hi_q <= dtc_pkg::RST_BYTE;
            // Pin history starts at the idle level: no false edge
            t_pin_q <= 2'b11;
            int_pin_q <= 2'b11;
            SFR_RDATA <= 8'h00;
        end else if (run_clk) begin // R15
            flags_q <= flags_d; // R14
            t0_lo_q <= t0_lo_d;
            t0_hi_q <= t0_hi_d;
            t1_lo_q <= t1_lo_d;
            t1_hi_q <= t1_hi_d;
            t_pin_q <= {COUNT_PIN1, COUNT_PIN0};
            int_pin_q <= int_lvl;
            if (wr_hit(SFR_ADDR, dtc_pkg::ADDR_TIMER_MODE_CONFIG)) begin
                mode_cfg_q <= SFR_WDATA;
            end
            if (wr_hit(SFR_ADDR, dtc_pkg::ADDR_CLOCK_RATE_SELECT)) begin
                rate_sel_q <= SFR_WDATA;
            end
            if (wr_hit(SFR_ADDR, dtc_pkg::ADDR_POWER_CONTROL)) begin
                pwr_ctl_q <= SFR_WDATA;
            end
            if (SFR_RD) begin
                SFR_RDATA <= rdata_d;
            end
        end
    end

    // ==========================================================
    // Status outputs from flip-flops
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            TIMER0_OVERFLOW_FLAG <= 1'b0;
            TIMER1_OVERFLOW_FLAG <= 1'b0;
            EXT_EXTERNAL_INTERRUPT_PIN_ZERO_DETECT_FLAG <= 1'b0;
            EXT_EXTERNAL_INTERRUPT_PIN_ONE_DETECT_FLAG <= 1'b0;
            CPU_CLOCK_STOP <= 1'b0;
        end else begin
            TIMER0_OVERFLOW_FLAG <= flags_out[dtc_pkg::T0_OVF_POS];
            TIMER1_OVERFLOW_FLAG <= flags_out[dtc_pkg::T1_OVF_POS];
            EXT_EXTERNAL_INTERRUPT_PIN_ZERO_DETECT_FLAG <= flags_out[dtc_pkg::X0_FLAG_POS];
            EXT_EXTERNAL_INTERRUPT_PIN_ONE_DETECT_FLAG <= flags_out[dtc_pkg::X1_FLAG_POS];
            // Idle or power down stops the core clock
            CPU_CLOCK_STOP <= pwr_ctl_q[dtc_pkg::HALT_CPU_POS] ||
                pwr_ctl_q[dtc_pkg::STOP_ALL_POS]; // R14
        end
    end
endmodule
`default_nettype wire
